// ==== tsa_pkg.sv ====
// tsa_pkg: constants, types and helpers shared by both link ends
// assumes one 125 MHz clock; tag bit period given in ns, rounded up to clock cycles
package tsa_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int CLK_NS = 8;
  localparam int TRS_MIN_US = 150;
  localparam int TRS_MAX_US = 1150;
  localparam int TRS_MIN_CYC = (TRS_MIN_US * CLK_MHZ + 0) / 1;
  localparam int TRS_MAX_CYC = (TRS_MAX_US * CLK_MHZ) / 1;
  localparam int TAG_BIT_NS = 25000;
  localparam int TAG_BIT_CYC = (TAG_BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIN_OPEN_QTR = 8;
  localparam int WIN_LEN_QTR = 11;
  localparam int QUIET_BITS = 3;
  localparam int START_BIT = 4;
  localparam int MAX_DELAY = 7;
  localparam int RESP_BITS = 16;
  localparam int FRAME_BITS = 16;
  localparam int FWD_BIT_CYC = 32;

  // ----------------------------------------
  // frame layout, msb sent first
  // ----------------------------------------
  localparam int PE_POS = 15;
  localparam int CODE_MSB = 14;
  localparam int CODE_LSB = 9;
  localparam int SIG_MSB = 8;
  localparam int SIG_LSB = 5;
  localparam int CRC_MSB = 4;
  localparam int SLOT_W = 9;
  localparam logic [8:0] ROUND_RST = 9'h001;

  localparam logic [5:0] CODE_NEXT_SLOT = 6'h02;
  localparam logic [5:0] CODE_STANDBY = 6'h04;
  localparam logic [5:0] CODE_RESET_READY = 6'h06;
  localparam logic [5:0] CODE_INIT_ALL = 6'h0a;
  localparam logic [5:0] CODE_RSV_LO = 6'h0b;
  localparam logic [5:0] CODE_RSV_HI = 6'h0f;
  localparam logic [4:0] CRC_POLY = 5'h09;
  localparam logic [4:0] CRC_PRESET = 5'h09;

  typedef enum logic [4:0] {
    TSA_READY = 5'b00001,
    TSA_QUIET = 5'b00010,
    TSA_SELECTED = 5'b00100,
    TSA_ACTIVE = 5'b01000,
    TSA_STANDBY = 5'b10000
  } tsa_state_t;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [4:0] tsa_crc5(input logic [10:0] d);
    logic [4:0] c;
    c = CRC_PRESET;
    for (int i = 10; i >= 0; i--)
    begin
      if (c[4] ^ d[i])
        c = {c[3:0], 1'b0} ^ CRC_POLY;
      else
        c = {c[3:0], 1'b0};
    end
    return c;
  endfunction

  function automatic logic tsa_reserved(input logic [5:0] c);
    return (c == 6'h00) || (c >= CODE_RSV_LO && c <= CODE_RSV_HI);
  endfunction

endpackage

// ==== tsa_link_if.sv ====
// tsa_link_if: logic-level air link between reader end and tag end
// assumes both ends share clk and rst_n
`timescale 1ns/1ps
`default_nettype none
interface tsa_link_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic cmd_start;
  logic cmd_eof;
  logic [15:0] cmd_frame;
  logic reader_mod;
  logic tag_tx;
  logic tag_bit;
  logic [3:0] tag_sig;

  modport tag_end (
    input clk, rst_n, cmd_start, cmd_eof, cmd_frame, reader_mod,
    output tag_tx, tag_bit, tag_sig
  );

  modport reader_end (
    input clk, rst_n, tag_tx, tag_bit, tag_sig,
    output cmd_start, cmd_eof, cmd_frame, reader_mod
  );
endinterface
`default_nettype wire

// ==== tsa_reader.sv ====
// tsa_reader: interrogator end, sends framed commands on the link
// assumes the tag end shares clk; requests come from reader logic
`timescale 1ns/1ps
`default_nettype none
module tsa_reader #(
  parameter int FWD_BIT_CYC = tsa_pkg::FWD_BIT_CYC
) (
  // link
  tsa_link_if.reader_end link,
  // command request
  input wire logic req,
  input wire logic [5:0] req_code,
  input wire logic [3:0] req_sig,
  input wire logic req_sync,
  output logic busy,
  // tag response
  output logic resp_valid,
  output logic [3:0] resp_sig,
  output logic [15:0] bit_period
);
  localparam int FRAME_CYC = tsa_pkg::FRAME_BITS * FWD_BIT_CYC;

  if (FWD_BIT_CYC < 1 || FRAME_CYC > 65535)
  begin : g_bad
    $error("tsa_reader: forward bit period out of range");
  end

  typedef enum logic [3:0] {
    RD_IDLE = 4'b0001,
    RD_WAIT = 4'b0010,
    RD_HOLD = 4'b0100,
    RD_SEND = 4'b1000
  } tsa_rd_t;

  tsa_rd_t st;
  logic tx_d;
  logic sync;
  logic [15:0] per_cnt;
  logic [17:0] hold_cnt;
  logic [17:0] hold_end;
  logic [15:0] send_cnt;

  // ----------------------------------------
  // tag bit period measurement
  // ----------------------------------------
  // measure tag clock
  always_ff @(posedge link.clk)
  begin
    if (!link.rst_n)
    begin
      tx_d <= 1'b0;
      per_cnt <= 16'h0000;
      bit_period <= 16'(tsa_pkg::TAG_BIT_CYC);
      resp_valid <= 1'b0;
      resp_sig <= 4'h0;
    end
    else
    begin
      tx_d <= link.tag_tx;
      resp_valid <= tx_d && !link.tag_tx;
      if (link.tag_tx)
        resp_sig <= link.tag_sig;
      if (link.tag_bit)
      begin
        per_cnt <= 16'h0000;
        if (tx_d)
          bit_period <= per_cnt + 16'h0001;
      end
      else if (per_cnt != 16'hffff)
        per_cnt <= per_cnt + 16'h0001;
    end
  end

  // three quiet bits, start in bit four
  assign hold_end = 18'(tsa_pkg::QUIET_BITS) * {2'b00, bit_period}
                    + {3'b000, bit_period[15:1]};

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_ff @(posedge link.clk)
  begin
    if (!link.rst_n)
    begin
      st <= RD_IDLE;
      sync <= 1'b0;
      busy <= 1'b0;
      hold_cnt <= 18'h00000;
      send_cnt <= 16'h0000;
      link.cmd_start <= 1'b0;
      link.cmd_eof <= 1'b0;
      link.cmd_frame <= 16'h0000;
      link.reader_mod <= 1'b0;
    end
    else
    begin
      link.cmd_start <= 1'b0;
      link.cmd_eof <= 1'b0;
      unique case (st)
        RD_IDLE:
          if (req)
          begin
            link.cmd_frame <= {1'b0, req_code, req_sig,
                               tsa_pkg::tsa_crc5({1'b0, req_code, req_sig})};
            sync <= req_sync;
            busy <= 1'b1;
            st <= RD_WAIT;
          end
        RD_WAIT:
          if (sync)
          begin
            if (tx_d && !link.tag_tx)
            begin
              hold_cnt <= 18'h00001;
              st <= RD_HOLD;
            end
          end
          else if (!link.tag_tx)
          begin
            link.cmd_start <= 1'b1;
            link.reader_mod <= 1'b1;
            send_cnt <= 16'(FRAME_CYC - 1);
            st <= RD_SEND;
          end
        RD_HOLD:
          if (hold_cnt >= hold_end)
          begin
            link.cmd_start <= 1'b1;
            link.reader_mod <= 1'b1;
            send_cnt <= 16'(FRAME_CYC - 1);
            st <= RD_SEND;
          end
          else
            hold_cnt <= hold_cnt + 18'h00001;
        RD_SEND:
          if (send_cnt == 16'h0000)
          begin
            link.cmd_eof <= 1'b1;
            link.reader_mod <= 1'b0;
            busy <= 1'b0;
            st <= RD_IDLE;
          end
          else
            send_cnt <= send_cnt - 16'h0001;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tsa_tag.sv ====
// tsa_tag: tag end, acknowledgement command handling and slot arbitration
// assumes the reader end shares clk; commands arrive whole at cmd_eof
`timescale 1ns/1ps
`default_nettype none
// Function
// - half-duplex; commands ignored while transmitting
// - reader acknowledges only inside 2.75-bit window
// - reader measures tag bit clock
// - reader quiet three bits before start
// - reader first falling edge in bit four
// - late slot-advance: stay arbitrating, count up
// - late round-suspend: go suspended, not chosen
// - codes 02 04 06 0a; reserved refused
// - slot-advance: ext bit, code, signature, crc
// - round-suspend: same layout, code 04
// - no reply; respond when counter hits slot
// - matched timely slot-advance silences; else count
// - slot-advance: ready/silenced keep, chosen silenced
// - suspended plus slot-advance: arbitrate and count
// - matched timely round-suspend makes tag chosen
// - other arbitrating tags suspend on round-suspend
// - round-suspend: chosen silenced, ready/silenced/suspended keep
// - reply starts 150 to 1150 us after eof
// - round end: new slot, new signature
// - random 0 to 7 bit delay before reply
module tsa_tag #(
  parameter int TRS_MIN = tsa_pkg::TRS_MIN_CYC,
  parameter int TRS_MAX = tsa_pkg::TRS_MAX_CYC,
  parameter int BIT_CYC = tsa_pkg::TAG_BIT_CYC
) (
  // link
  tsa_link_if.tag_end link,
  // arbitration state
  output var tsa_pkg::tsa_state_t state,
  output logic [8:0] slot_cnt,
  output logic [8:0] chosen_slot,
  output logic [8:0] round_size,
  output logic [3:0] signature,
  output logic answered,
  // events
  output logic ack_pulse,
  output logic drop_pulse
);
  localparam int WIN_OPEN = BIT_CYC * tsa_pkg::WIN_OPEN_QTR / 4;
  localparam int WIN_CLOSE = BIT_CYC
                             * (tsa_pkg::WIN_OPEN_QTR + tsa_pkg::WIN_LEN_QTR) / 4;

  if (TRS_MIN < 1 || BIT_CYC < 4 || TRS_MAX >= (1 << 24)
      || TRS_MIN + tsa_pkg::MAX_DELAY * BIT_CYC >= TRS_MAX)
  begin : g_bad
    $error("tsa_tag: reply delay cannot meet turnaround bounds");
  end

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_SEND = 3'b100
  } tsa_tx_t;

  tsa_tx_t tx;
  logic [15:0] lfsr;
  logic [23:0] tx_cnt;
  logic [4:0] bit_idx;
  logic [23:0] win_tmr;
  logic win_ok;
  logic [5:0] code;
  logic cmd_take;
  logic frame_ok;
  logic acked;
  logic advance;
  logic restart;
  logic resp_go;
  logic last_bit;
  tsa_pkg::tsa_state_t next_state;
  logic [8:0] next_slot;
  logic [8:0] next_chosen;
  logic [8:0] next_size;
  logic [3:0] next_sig;
  logic next_ack;
  logic next_drop;

  function automatic logic [8:0] pick_slot(input logic [8:0] rnd, input logic [8:0] size);
    return 9'h001 + (rnd & (size - 9'h001));
  endfunction

  // ----------------------------------------
  // frame checks
  // ----------------------------------------
  assign code = link.cmd_frame[tsa_pkg::CODE_MSB:tsa_pkg::CODE_LSB];
  assign cmd_take = link.cmd_eof && (tx != TX_SEND);
  assign frame_ok = !link.cmd_frame[tsa_pkg::PE_POS] && !tsa_pkg::tsa_reserved(code)
                    && tsa_pkg::tsa_crc5(link.cmd_frame[15:5])
                       == link.cmd_frame[tsa_pkg::CRC_MSB:0];
  assign acked = answered && win_ok
                 && link.cmd_frame[tsa_pkg::SIG_MSB:tsa_pkg::SIG_LSB] == signature;
  assign last_bit = (tx == TX_SEND) && (tx_cnt == 24'h000000)
                    && (bit_idx == 5'(tsa_pkg::RESP_BITS - 1));

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_slot = slot_cnt;
    next_chosen = chosen_slot;
    next_size = round_size;
    next_sig = signature;
    advance = 1'b0;
    restart = 1'b0;
    next_ack = 1'b0;
    next_drop = 1'b0;
    if (cmd_take && !frame_ok)
      next_drop = 1'b1;
    else if (cmd_take && code == tsa_pkg::CODE_NEXT_SLOT)
    begin
      unique case (state)
        tsa_pkg::TSA_READY, tsa_pkg::TSA_QUIET: ;
        tsa_pkg::TSA_SELECTED: next_state = tsa_pkg::TSA_QUIET;
        tsa_pkg::TSA_ACTIVE:
          // silence or count, late stays active
          if (acked)
          begin
            next_state = tsa_pkg::TSA_QUIET;
            next_ack = 1'b1;
          end
          else
            advance = 1'b1;
        tsa_pkg::TSA_STANDBY:
          begin
            next_state = tsa_pkg::TSA_ACTIVE;
            advance = 1'b1;
          end
      endcase
    end
    else if (cmd_take && code == tsa_pkg::CODE_STANDBY)
    begin
      unique case (state)
        tsa_pkg::TSA_READY, tsa_pkg::TSA_QUIET, tsa_pkg::TSA_STANDBY: ;
        tsa_pkg::TSA_SELECTED: next_state = tsa_pkg::TSA_QUIET;
        tsa_pkg::TSA_ACTIVE:
          if (acked)
          begin
            next_state = tsa_pkg::TSA_SELECTED;
            next_ack = 1'b1;
          end
          else
            next_state = tsa_pkg::TSA_STANDBY;
      endcase
    end
    else if (cmd_take && code == tsa_pkg::CODE_RESET_READY)
    begin
      next_state = tsa_pkg::TSA_READY;
      next_slot = 9'h000;
      next_chosen = 9'h000;
    end
    else if (cmd_take && code == tsa_pkg::CODE_INIT_ALL)
    begin
      unique case (state)
        tsa_pkg::TSA_QUIET: ;
        tsa_pkg::TSA_SELECTED: next_state = tsa_pkg::TSA_QUIET;
        tsa_pkg::TSA_READY, tsa_pkg::TSA_ACTIVE, tsa_pkg::TSA_STANDBY:
          begin
            next_state = tsa_pkg::TSA_ACTIVE;
            next_size = 9'h002 << link.cmd_frame[tsa_pkg::SIG_LSB + 2:tsa_pkg::SIG_LSB];
            restart = 1'b1;
          end
      endcase
    end
    if (restart)
    begin
      next_slot = 9'h001;
      next_chosen = pick_slot(lfsr[8:0], next_size);
      next_sig = lfsr[12:9];
    end
    else if (advance)
    begin
      // round exhausted: new slot and signature
      if (slot_cnt >= round_size)
      begin
        next_slot = 9'h001;
        next_chosen = pick_slot(lfsr[8:0], round_size);
        next_sig = lfsr[12:9];
      end
      else
        next_slot = slot_cnt + 9'h001;
    end
  end

  // reply only when counter meets slot
  assign resp_go = (restart || advance) && (next_slot == next_chosen);

  // ----------------------------------------
  // arbitration registers
  // ----------------------------------------
  always_ff @(posedge link.clk)
  begin
    if (!link.rst_n)
    begin
      state <= tsa_pkg::TSA_READY;
      slot_cnt <= 9'h000;
      chosen_slot <= 9'h000;
      round_size <= tsa_pkg::ROUND_RST;
      signature <= 4'h0;
      ack_pulse <= 1'b0;
      drop_pulse <= 1'b0;
    end
    else
    begin
      state <= next_state;
      slot_cnt <= next_slot;
      chosen_slot <= next_chosen;
      round_size <= next_size;
      signature <= next_sig;
      ack_pulse <= next_ack;
      drop_pulse <= next_drop;
    end
  end

  always_ff @(posedge link.clk)
  begin
    if (!link.rst_n)
      lfsr <= 16'hace1;
    else
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  end

  // ----------------------------------------
  // reply timing and transmission
  // ----------------------------------------
  always_ff @(posedge link.clk)
  begin
    if (!link.rst_n)
    begin
      tx <= TX_IDLE;
      tx_cnt <= 24'h000000;
      bit_idx <= 5'h00;
      link.tag_tx <= 1'b0;
      link.tag_bit <= 1'b0;
      link.tag_sig <= 4'h0;
    end
    else
    begin
      link.tag_bit <= 1'b0;
      link.tag_sig <= signature;
      unique case (tx)
        TX_IDLE, TX_WAIT:
          if (resp_go)
          begin
            tx <= TX_WAIT;
            tx_cnt <= 24'(TRS_MIN - 1) + 24'(lfsr[15:13]) * 24'(BIT_CYC);
          end
          else if (tx == TX_WAIT && cmd_take)
            tx <= TX_IDLE;
          else if (tx == TX_WAIT && tx_cnt == 24'h000000)
          begin
            tx <= TX_SEND;
            link.tag_tx <= 1'b1;
            link.tag_bit <= 1'b1;
            bit_idx <= 5'h00;
            tx_cnt <= 24'(BIT_CYC - 1);
          end
          else if (tx == TX_WAIT)
            tx_cnt <= tx_cnt - 24'h000001;
        TX_SEND:
          if (last_bit)
          begin
            tx <= TX_IDLE;
            link.tag_tx <= 1'b0;
          end
          else if (tx_cnt == 24'h000000)
          begin
            bit_idx <= bit_idx + 5'h01;
            link.tag_bit <= 1'b1;
            tx_cnt <= 24'(BIT_CYC - 1);
          end
          else
            tx_cnt <= tx_cnt - 24'h000001;
      endcase
    end
  end

  // set at end of reply wins over clear
  always_ff @(posedge link.clk)
  begin
    if (!link.rst_n)
      answered <= 1'b0;
    else if (last_bit)
      answered <= 1'b1;
    else if (cmd_take)
      answered <= 1'b0;
  end

  // ----------------------------------------
  // acknowledgement window
  // ----------------------------------------
  // window from bit two/three for 2.75 bits
  always_ff @(posedge link.clk)
  begin
    if (!link.rst_n)
    begin
      win_tmr <= 24'(WIN_CLOSE);
      win_ok <= 1'b0;
    end
    else
    begin
      if (tx == TX_SEND)
        win_tmr <= 24'h000000;
      else if (win_tmr != 24'(WIN_CLOSE))
        win_tmr <= win_tmr + 24'h000001;
      if (tx == TX_SEND)
        win_ok <= 1'b0;
      else if (link.cmd_start)
        win_ok <= (win_tmr >= 24'(WIN_OPEN)) && (win_tmr < 24'(WIN_CLOSE));
    end
  end
endmodule
`default_nettype wire

// ==== tsa_link_asserts.sv ====
// tsa_link_asserts: concurrent checks on the reader-to-tag link
// assumes one clock; instantiated beside the link interface
`timescale 1ns/1ps
`default_nettype none
module tsa_link_asserts #(
  parameter int TRS_MIN = 20,
  parameter int TRS_MAX = 400,
  parameter int BIT_CYC = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // reader side
  input wire logic cmd_start,
  input wire logic cmd_eof,
  input wire logic [15:0] cmd_frame,
  input wire logic reader_mod,
  // tag side
  input wire logic tag_tx,
  input wire logic tag_bit,
  input wire logic [3:0] tag_sig
);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  int eof_cnt;
  int tx_cnt;
  int bit_cnt;
  // cycles since the last end of frame, saturating
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      eof_cnt <= TRS_MAX + 1;
    else if (cmd_eof)
      eof_cnt <= 1;
    else if (eof_cnt <= TRS_MAX)
      eof_cnt <= eof_cnt + 1;
  end
  // length and bit count of the running reply
  always_ff @(posedge clk)
  begin
    tx_cnt <= (rst_n && tag_tx) ? tx_cnt + 1 : 0;
    bit_cnt <= (rst_n && tag_tx) ? bit_cnt + int'(tag_bit) : 0;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_half_duplex;
    cmd_start |-> !tag_tx;
  endproperty
  a_half_duplex: assert property (p_half_duplex) else $error("start while tag sends");
  property p_mod_end;
    cmd_eof |-> !reader_mod && $past(reader_mod);
  endproperty
  a_mod_end: assert property (p_mod_end) else $error("frame end without carrier gap");
  property p_ext_bit;
    cmd_eof |-> !cmd_frame[15];
  endproperty
  a_ext_bit: assert property (p_ext_bit) else $error("extension bit set");
  property p_frame_stable;
    reader_mod && $past(reader_mod) |-> $stable(cmd_frame);
  endproperty
  a_frame_stable: assert property (p_frame_stable) else $error("frame moved in flight");
  property p_reply_delay;
    $rose(tag_tx) |-> eof_cnt > TRS_MIN && eof_cnt <= TRS_MAX;
  endproperty
  a_reply_delay: assert property (p_reply_delay) else $error("reply turnaround out of range");
  property p_reply_jitter;
    $rose(tag_tx) |-> eof_cnt <= TRS_MIN + 7 * BIT_CYC + 1;
  endproperty
  a_reply_jitter: assert property (p_reply_jitter) else $error("reply delay above 7 bits");
  property p_reply_len;
    $fell(tag_tx) |-> tx_cnt == tsa_pkg::RESP_BITS * BIT_CYC;
  endproperty
  a_reply_len: assert property (p_reply_len) else $error("reply length wrong");
  property p_bit_count;
    $fell(tag_tx) |-> bit_cnt == tsa_pkg::RESP_BITS && $past(tag_sig) == tag_sig;
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("reply bit count wrong");
  c_reply: cover property ($rose(tag_tx));
  c_suspend: cover property (cmd_eof && cmd_frame[14:9] == 6'h04);
  c_reserved: cover property (cmd_eof && cmd_frame[14:9] == 6'h0b);
endmodule
`default_nettype wire

// ==== tag_slot_ack_handler_tb.sv ====
// tag_slot_ack_handler_tb: reader and tag joined, driven from the reader
// assumes shortened tag timing and a fast forward link
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("mismatch %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module tag_slot_ack_handler_tb;
  localparam tsa_pkg::tsa_state_t RDY = tsa_pkg::TSA_READY;
  localparam tsa_pkg::tsa_state_t QUI = tsa_pkg::TSA_QUIET;
  localparam tsa_pkg::tsa_state_t SEL = tsa_pkg::TSA_SELECTED;
  localparam tsa_pkg::tsa_state_t ACT = tsa_pkg::TSA_ACTIVE;
  localparam tsa_pkg::tsa_state_t STB = tsa_pkg::TSA_STANDBY;
  localparam logic [5:0] NS = tsa_pkg::CODE_NEXT_SLOT;
  localparam logic [5:0] SB = tsa_pkg::CODE_STANDBY;
  // shortened timing shared by the tag and the checker; TB_FWD_CYC goes to the reader only
  localparam int TB_TRS_MIN = 20;
  localparam int TB_TRS_MAX = 400;
  localparam int TB_BIT_CYC = 40;
  localparam int TB_FWD_CYC = 2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic [5:0] req_code = 6'h00;
  logic [3:0] req_sig = 4'h0;
  logic req_sync = 1'b0;
  logic busy, resp_valid, answered, ack_pulse, drop_pulse, got_ack, got_drop;
  logic [3:0] resp_sig, signature;
  logic [15:0] bit_period;
  logic [8:0] slot_cnt, chosen_slot, round_size, e;
  tsa_pkg::tsa_state_t state;
  int fail_count = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  tsa_link_if i_tsa_link_if (.clk(clk), .rst_n(rst_n));
  tsa_reader #(.FWD_BIT_CYC(TB_FWD_CYC)) i_tsa_reader (.link(i_tsa_link_if), .req(req),
    .req_code(req_code), .req_sig(req_sig), .req_sync(req_sync), .busy(busy),
    .resp_valid(resp_valid), .resp_sig(resp_sig), .bit_period(bit_period));
  tsa_tag #(.TRS_MIN(TB_TRS_MIN), .TRS_MAX(TB_TRS_MAX), .BIT_CYC(TB_BIT_CYC)) i_tsa_tag (
    .link(i_tsa_link_if),
    .state(state), .slot_cnt(slot_cnt), .chosen_slot(chosen_slot),
    .round_size(round_size), .signature(signature), .answered(answered),
    .ack_pulse(ack_pulse), .drop_pulse(drop_pulse));
  tsa_link_asserts #(.TRS_MIN(TB_TRS_MIN), .TRS_MAX(TB_TRS_MAX), .BIT_CYC(TB_BIT_CYC))
    i_tsa_link_asserts (
    .clk(clk), .rst_n(rst_n), .cmd_start(i_tsa_link_if.cmd_start),
    .cmd_eof(i_tsa_link_if.cmd_eof), .cmd_frame(i_tsa_link_if.cmd_frame),
    .reader_mod(i_tsa_link_if.reader_mod), .tag_tx(i_tsa_link_if.tag_tx),
    .tag_bit(i_tsa_link_if.tag_bit), .tag_sig(i_tsa_link_if.tag_sig));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic logic [8:0] nxt(input logic [8:0] s, input logic [8:0] r);
    return (s >= r) ? 9'h001 : s + 9'h001;
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one command, then sample pulses in the cycle after its frame end
  task automatic cmd(input logic [5:0] c, input logic [3:0] s, input logic y);
    int k;
    @(negedge clk);
    req = 1'b1;
    req_code = c;
    req_sig = s;
    req_sync = y;
    @(negedge clk);
    req = 1'b0;
    k = 0;
    while (i_tsa_link_if.cmd_eof !== 1'b1 && k < 5000)
    begin
      @(negedge clk);
      k++;
    end
    `CHK("frame end", 1'b1, i_tsa_link_if.cmd_eof)
    `CHK("busy", 1'b0, busy)
    @(negedge clk);
    got_ack = ack_pulse;
    got_drop = drop_pulse;
  endtask
  task automatic wait_tx_end();
    int k;
    k = 0;
    while (i_tsa_link_if.tag_tx !== 1'b1 && k < 2000)
    begin
      @(negedge clk);
      k++;
    end
    `CHK("reply seen", 1'b1, i_tsa_link_if.tag_tx)
    while (i_tsa_link_if.tag_tx !== 1'b0 && k < 4000)
    begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    `CHK("resp_valid", 1'b1, resp_valid)
  endtask
  // step slots until the tag's own slot comes up
  task automatic advance();
    for (int i = 0; i < 8; i++)
    begin
      if (state === ACT && slot_cnt === chosen_slot)
        break;
      e = nxt(slot_cnt, round_size);
      cmd(NS, 4'h0, 1'b0);
      `CHK("slot_cnt", e, slot_cnt)
    end
  endtask
  task automatic restart();
    cmd(tsa_pkg::CODE_RESET_READY, 4'h0, 1'b0);
    `CHK("state", RDY, state)
    cmd(tsa_pkg::CODE_INIT_ALL, 4'h0, 1'b0);
    `CHK("state", ACT, state)
    `CHK("round_size", 9'h002, round_size)
    advance();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_idle();
    logic [5:0] rsv [6] = '{6'h00, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f};
    `CHK("round_size", 9'h001, round_size)
    cmd(NS, 4'h0, 1'b0);
    `CHK("state", RDY, state)
    cmd(SB, 4'h0, 1'b0);
    `CHK("state", RDY, state)
    foreach (rsv[i])
    begin
      cmd(rsv[i], 4'h0, 1'b0);
      `CHK("drop", 1'b1, got_drop)
      `CHK("state", RDY, state)
    end
  endtask
  task automatic t_ack_next();
    restart();
    cmd(NS, signature, 1'b1);
    `CHK("ack", 1'b1, got_ack)
    `CHK("state", QUI, state)
    `CHK("bit_period", 16'h0028, bit_period)
    `CHK("resp_sig", signature, resp_sig)
    cmd(SB, 4'h0, 1'b0);
    `CHK("state", QUI, state)
    cmd(NS, 4'h0, 1'b0);
    `CHK("state", QUI, state)
  endtask
  task automatic t_ack_suspend();
    for (int k = 0; k < 2; k++)
    begin
      restart();
      cmd(SB, signature, 1'b1);
      `CHK("ack", 1'b1, got_ack)
      `CHK("state", SEL, state)
      cmd((k == 0) ? NS : SB, 4'h0, 1'b0);
      `CHK("state", QUI, state)
    end
  endtask
  task automatic t_late();
    restart();
    wait_tx_end();
    e = nxt(slot_cnt, round_size);
    cmd(NS, signature, 1'b0);
    `CHK("ack", 1'b0, got_ack)
    `CHK("state", ACT, state)
    `CHK("slot_cnt", e, slot_cnt)
    advance();
    wait_tx_end();
    cmd(SB, signature, 1'b0);
    `CHK("ack", 1'b0, got_ack)
    `CHK("state", STB, state)
    e = nxt(slot_cnt, round_size);
    cmd(NS, 4'h0, 1'b0);
    `CHK("state", ACT, state)
    `CHK("slot_cnt", e, slot_cnt)
  endtask
  task automatic t_mismatch();
    advance();
    e = nxt(slot_cnt, round_size);
    cmd(NS, signature ^ 4'h1, 1'b1);
    `CHK("ack", 1'b0, got_ack)
    `CHK("state", ACT, state)
    `CHK("slot_cnt", e, slot_cnt)
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_idle();
    t_ack_next();
    t_ack_suspend();
    t_late();
    t_mismatch();
    tally_and_finish();
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
